//--- inc/sbp_map.svh
// Purpose: constants of the burst sram port (offsets, widths, counts)
// Assumes: one core clock; one beat per clock cycle
// Notes:   included by the package and the design modules
//
// Overview of operation
// - write data is taken on every K and K-bar beat of a write.
// - write port select, active low, sampled on K; low starts a write.
// - write data inputs are ignored while the write port is deselected, except on beats 1..3 of a write under way.
// - 8-bit mode: nibble mask 0 gates bits 3..0, mask 1 bits 7..4.
// - each nibble mask is sampled on the same edge as its data beat.
// - a deselected nibble mask drops that nibble; array keeps it.
// - 9/18/36-bit modes: lane mask i gates one 9-bit lane.
// - masked lanes stay exactly as stored before the beat.
// - each lane mask is sampled on the same edge as its data beat.
// - one shared address bus, sampled on K when an access starts.
// - four sub-arrays; burst address is 19, 18 or 17 bits wide.
// - address is ignored for a port not selected this cycle.
// - read data is driven on each C and C-bar (or K) beat.
// - read port select, active low, sampled on K; low starts a read.
// - a read under way completes even after the port is deselected.
// - data outputs go high impedance after the next C rising edge.
// - each read returns four sequential words from the address.
// - a free-running echo clock pair follows the output clocks.
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

`define SBP_BURST_LEN   4
`define SBP_BEAT_W      2
`define SBP_LAST_BEAT   2'h3
`define SBP_DATA_W_DEF  36
`define SBP_ADDR_W_DEF  17
`define SBP_NIB_W       4
`define SBP_LANE_W      9
`define SBP_MAX_LANES   4
`define SBP_NIB_LANES   2
`define SBP_MAX_DATA_W  36
`define SBP_MAX_AW      21
`define SBP_PHASE_K     1'b0
`define SBP_PHASE_KB    1'b1

`endif

//--- inc/sbp_pkg.sv
// Purpose: shared types of the burst sram port
// Assumes: widths no larger than the maxima in sbp_map.svh
// Notes:   the struct carries one write beat to the array
`include "sbp_map.svh"

package sbp_pkg;

  typedef struct packed {
    logic                         we;
    logic [`SBP_MAX_LANES-1:0]    lane_en;
    logic [`SBP_MAX_AW-1:0]       addr;
    logic [`SBP_MAX_DATA_W-1:0]   data;
  } sbp_wbeat_t;

  typedef enum logic [1:0] {
    SBP_IDLE  = 2'h1,
    SBP_BURST = 2'h2
  } sbp_port_state_t;

endpackage

//--- verilog/sbp_echo.sv
// Purpose: beat phase and free-running echo clock pair
// Assumes: one core cycle per K or K-bar beat
// Notes:   phase 0 is the K beat, phase 1 the K-bar beat
`timescale 1ns/1ns
`include "sbp_map.svh"

module sbp_echo
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // beat phase and echo pair
  output logic      phase_o,
  output logic      echo_clock_o,
  output logic      echo_clock_n_o
);

  logic phase_reg;
  logic phase_next;
  logic echo_reg;
  logic echo_n_reg;

  assign phase_next = ~phase_reg;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_reg <= `SBP_PHASE_K;
    else
      phase_reg <= phase_next;
  end

  // echo pair runs free, high during the K beat
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      echo_reg   <= 1'b1;
      echo_n_reg <= 1'b0;
    end
    else
    begin
      echo_reg   <= (phase_next == `SBP_PHASE_K);
      echo_n_reg <= (phase_next == `SBP_PHASE_KB);
    end
  end

  assign phase_o        = phase_reg;
  assign echo_clock_o   = echo_reg;
  assign echo_clock_n_o = echo_n_reg;

endmodule // sbp_echo

//--- verilog/sbp_mem.sv
// Purpose: storage array with per-lane write and registered read
// Assumes: one write beat and one read per cycle
// Notes:   no reset on the array; contents are unknown after power-up
`timescale 1ns/1ns
`include "sbp_map.svh"

module sbp_mem
#(
  parameter int DATA_W = `SBP_DATA_W_DEF,
  parameter int LANE_W = `SBP_LANE_W,
  parameter int NLANES = `SBP_MAX_LANES,
  parameter int AW     = `SBP_ADDR_W_DEF + `SBP_BEAT_W
)
(
  // clock
  input  wire logic               mclk_i,
  // write beat
  input  wire sbp_pkg::sbp_wbeat_t wbeat_i,
  // read port
  input  wire logic               re_i,
  input  wire logic [AW-1:0]      raddr_i,
  output logic      [DATA_W-1:0]  rdata_o
);

  logic [DATA_W-1:0] mem_array [0:(1<<AW)-1];
  logic [DATA_W-1:0] rdata_reg;
  logic [AW-1:0]     waddr;

  assign waddr = wbeat_i.addr[AW-1:0];

  // one writing process only: the array must not have several drivers
  // a masked lane keeps its old bits
  always_ff @(posedge mclk_i)
  begin
    for (int i = 0; i < NLANES; i++)
    begin
      if (wbeat_i.we && wbeat_i.lane_en[i])
        mem_array[waddr][i*LANE_W +: LANE_W] <=
          wbeat_i.data[i*LANE_W +: LANE_W];
    end
  end

  // read of a word being written returns the old value
  always_ff @(posedge mclk_i)
  begin
    if (re_i)
      rdata_reg <= mem_array[raddr_i];
  end

  assign rdata_o = rdata_reg;

endmodule // sbp_mem

//--- verilog/sbp_port.sv
// Purpose: separate read/write port logic of a four-word burst sram
// Assumes: host pins are driven by logic on mclk_i; one beat per cycle
// Notes:   C/C-bar and K/K-bar beats coincide in this single-clock model
`timescale 1ns/1ns
`include "sbp_map.svh"

module sbp_port
#(
  parameter int DATA_W = `SBP_DATA_W_DEF,
  parameter int ADDR_W = `SBP_ADDR_W_DEF
)
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // shared address and port selects
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              write_port_select_n_i,
  input  wire logic              read_port_select_n_i,
  // write data and masks
  input  wire logic [DATA_W-1:0] d_i,
  input  wire logic [`SBP_NIB_LANES-1:0] nibble_write_mask_n_i,
  input  wire logic [`SBP_MAX_LANES-1:0] lane_write_mask_n_i,
  // read data
  output logic      [DATA_W-1:0] q_o,
  output logic                   q_oe_o,
  // echo clocks
  output logic                   echo_clock_o,
  output logic                   echo_clock_n_o
);

  // 8-bit parts use nibble lanes, the others 9-bit lanes
  localparam int LANE_W = (DATA_W == 8) ? `SBP_NIB_W : `SBP_LANE_W;
  localparam int NLANES = DATA_W / LANE_W;
  localparam int MEM_AW = ADDR_W + `SBP_BEAT_W;

  logic phase;
  logic k_beat;

  // write side state
  sbp_pkg::sbp_port_state_t  wr_state_reg;
  sbp_pkg::sbp_port_state_t  wr_state_next;
  logic [`SBP_BEAT_W-1:0]    wr_cnt_reg;
  logic [`SBP_BEAT_W-1:0]    wr_cnt_next;
  logic [ADDR_W-1:0]         wr_addr_reg;
  logic                      wr_start;
  logic                      wr_beat;
  logic [MEM_AW-1:0]         wr_mem_addr;
  logic [NLANES-1:0]         lane_en;
  sbp_pkg::sbp_wbeat_t       wbeat;

  // read side state
  sbp_pkg::sbp_port_state_t  rd_state_reg;
  sbp_pkg::sbp_port_state_t  rd_state_next;
  logic [`SBP_BEAT_W-1:0]    rd_cnt_reg;
  logic [`SBP_BEAT_W-1:0]    rd_cnt_next;
  logic [ADDR_W-1:0]         rd_addr_reg;
  logic                      rd_start;
  logic                      rd_issue;
  logic [MEM_AW-1:0]         rd_mem_addr;
  logic                      rd_pipe_reg;
  logic [DATA_W-1:0]         mem_rdata;
  logic [DATA_W-1:0]         q_reg;
  logic                      q_oe_reg;

  sbp_echo u_echo
  (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .phase_o        (phase),
    .echo_clock_o   (echo_clock_o),
    .echo_clock_n_o (echo_clock_n_o)
  );

  assign k_beat = (phase == `SBP_PHASE_K);

  // selects count only on a K beat, and only between bursts
  assign wr_start = k_beat && !write_port_select_n_i
                    && (wr_state_reg == sbp_pkg::SBP_IDLE);
  assign rd_start = k_beat && !read_port_select_n_i
                    && (rd_state_reg == sbp_pkg::SBP_IDLE);

  // write burst: beat 0 on the starting K, beats 1..3 after
  always_comb
  begin
    wr_state_next = wr_state_reg;
    wr_cnt_next   = wr_cnt_reg;
    case (wr_state_reg)
      sbp_pkg::SBP_IDLE:
      begin
        if (wr_start)
        begin
          wr_state_next = sbp_pkg::SBP_BURST;
          wr_cnt_next   = `SBP_BEAT_W'(1);
        end
      end
      sbp_pkg::SBP_BURST:
      begin
        wr_cnt_next = wr_cnt_reg + `SBP_BEAT_W'(1);
        if (wr_cnt_reg == `SBP_LAST_BEAT)
        begin
          wr_state_next = sbp_pkg::SBP_IDLE;
          wr_cnt_next   = '0;
        end
      end
      default:
      begin
        wr_state_next = sbp_pkg::SBP_IDLE;
        wr_cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_state_reg <= sbp_pkg::SBP_IDLE;
      wr_cnt_reg   <= '0;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      wr_cnt_reg   <= wr_cnt_next;
    end
  end

  // address taken only when the write port is selected
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      wr_addr_reg <= '0;
    else if (wr_start)
      wr_addr_reg <= addr_i;
  end

  // data beats outside a write are never passed on
  assign wr_beat = wr_start
                   || (wr_state_reg == sbp_pkg::SBP_BURST);
  assign wr_mem_addr = wr_start ? {addr_i, `SBP_BEAT_W'(0)}
                                : {wr_addr_reg, wr_cnt_reg};

  // masks are taken in the same cycle as the beat they qualify
  for (genvar i = 0; i < NLANES; i++)
  begin : g_mask
    if (DATA_W == 8)
    begin : g_nib
      assign lane_en[i] = !nibble_write_mask_n_i[i];
    end
    else
    begin : g_byte
      assign lane_en[i] = !lane_write_mask_n_i[i];
    end
  end

  always_comb
  begin
    wbeat         = '0;
    wbeat.we      = wr_beat;
    wbeat.lane_en[NLANES-1:0] = lane_en;
    wbeat.addr[MEM_AW-1:0]    = wr_mem_addr;
    wbeat.data[DATA_W-1:0]    = d_i;
  end

  // read burst: word 0 fetched on the starting K, words 1..3 after
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rd_cnt_next   = rd_cnt_reg;
    case (rd_state_reg)
      sbp_pkg::SBP_IDLE:
      begin
        if (rd_start)
        begin
          rd_state_next = sbp_pkg::SBP_BURST;
          rd_cnt_next   = `SBP_BEAT_W'(1);
        end
      end
      sbp_pkg::SBP_BURST:
      begin
        // the select is not looked at here, so a burst always ends
        rd_cnt_next = rd_cnt_reg + `SBP_BEAT_W'(1);
        if (rd_cnt_reg == `SBP_LAST_BEAT)
        begin
          rd_state_next = sbp_pkg::SBP_IDLE;
          rd_cnt_next   = '0;
        end
      end
      default:
      begin
        rd_state_next = sbp_pkg::SBP_IDLE;
        rd_cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_state_reg <= sbp_pkg::SBP_IDLE;
      rd_cnt_reg   <= '0;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      rd_cnt_reg   <= rd_cnt_next;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_addr_reg <= '0;
    else if (rd_start)
      rd_addr_reg <= addr_i;
  end

  // four sequential words from the latched location
  assign rd_issue    = rd_start || (rd_state_reg == sbp_pkg::SBP_BURST);
  assign rd_mem_addr = rd_start ? {addr_i, `SBP_BEAT_W'(0)}
                                : {rd_addr_reg, rd_cnt_reg};

  sbp_mem
  #(
    .DATA_W (DATA_W),
    .LANE_W (LANE_W),
    .NLANES (NLANES),
    .AW     (MEM_AW)
  )
  u_mem
  (
    .mclk_i  (mclk_i),
    .wbeat_i (wbeat),
    .re_i    (rd_issue),
    .raddr_i (rd_mem_addr),
    .rdata_o (mem_rdata)
  );

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_pipe_reg <= 1'b0;
    else
      rd_pipe_reg <= rd_issue;
  end

  // output register: one word per C or C-bar beat
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      q_reg <= '0;
    else if (rd_pipe_reg)
      q_reg <= mem_rdata;
  end

  // drivers released on the beat after the last word
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      q_oe_reg <= 1'b0;
    else
      q_oe_reg <= rd_pipe_reg;
  end

  assign q_o    = q_reg;
  assign q_oe_o = q_oe_reg;

endmodule // sbp_port

//--- verification/sbp_port_properties.sv
// Purpose: port timing checks for sbp_port
// Assumes: one clock, async active-high reset
// Notes:   read latency left open; burst shape fixed
`timescale 1ns/1ns
`include "sbp_map.svh"

module sbp_port_properties
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
)
(
  // clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  // host pins
  input  wire logic [ADDR_W-1:0]          addr_i,
  input  wire logic                       write_port_select_n_i,
  input  wire logic                       read_port_select_n_i,
  input  wire logic [DATA_W-1:0]          d_i,
  input  wire logic [`SBP_NIB_LANES-1:0]  nibble_write_mask_n_i,
  input  wire logic [`SBP_MAX_LANES-1:0]  lane_write_mask_n_i,
  // device outputs
  input  wire logic [DATA_W-1:0]          q_o,
  input  wire logic                       q_oe_o,
  input  wire logic                       echo_clock_o,
  input  wire logic                       echo_clock_n_o
);
  logic [1:0] busy_reg;
  logic [3:0] since_reg;
  logic [2:0] run_reg;
  logic       rd_start;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // start only on a k beat with the read side idle
  assign rd_start = echo_clock_o && !read_port_select_n_i && busy_reg == 2'h0;

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      busy_reg <= 2'h0;
    else if (rd_start)
      busy_reg <= 2'h3;
    else if (busy_reg != 2'h0)
      busy_reg <= busy_reg - 2'h1;

  // saturates so a long idle stretch never wraps
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      since_reg <= 4'hF;
    else if (rd_start)
      since_reg <= 4'h0;
    else if (since_reg != 4'hF)
      since_reg <= since_reg + 4'h1;

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      run_reg <= 3'h0;
    else if (q_oe_o)
      run_reg <= run_reg + 3'h1;
    else
      run_reg <= 3'h0;

  sequence s_fresh;
    $rose(q_oe_o);
  endsequence

  sequence s_burst;
    q_oe_o [*4];
  endsequence

  AST_ECHO_TOGGLE: assert property (!$past(rst_i) |->
    echo_clock_o != $past(echo_clock_o)) else $error("echo stuck");
  AST_ECHO_PAIR: assert property (echo_clock_n_o == !echo_clock_o)
    else $error("echo pair not inverse");
  AST_ECHO_START: assert property ($past(rst_i) |-> echo_clock_o)
    else $error("first beat after reset not k");
  AST_RD_FIRST_K: assert property (s_fresh |-> echo_clock_o)
    else $error("read burst not on k beat");
  AST_RD_FOUR: assert property (s_fresh |-> s_burst)
    else $error("read burst shorter than four");
  AST_RD_CAUSE: assert property (s_fresh |-> $past(rd_start, 2) ||
    $past(rd_start, 3) || $past(rd_start, 4)) else $error("read no cause");
  AST_RD_WHOLE: assert property ($fell(q_oe_o) |-> run_reg[1:0] == 2'h0)
    else $error("read burst cut short");
  AST_RD_IDLE: assert property (since_reg >= 4'h8 |-> !q_oe_o)
    else $error("outputs not released");
endmodule // sbp_port_properties

bind sbp_port sbp_port_properties #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
  u_sbp_port_properties (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
  .write_port_select_n_i(write_port_select_n_i),
  .read_port_select_n_i(read_port_select_n_i), .d_i(d_i),
  .nibble_write_mask_n_i(nibble_write_mask_n_i),
  .lane_write_mask_n_i(lane_write_mask_n_i), .q_o(q_o), .q_oe_o(q_oe_o),
  .echo_clock_o(echo_clock_o), .echo_clock_n_o(echo_clock_n_o));

//--- verification/sbp_host_model.sv
// Purpose: host controller model driving the burst sram port
// Assumes: echo_clock_i high marks a k beat
// Notes:   idle pins carry noise, never a held value
`timescale 1ns/1ns

module sbp_host_model
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
)
(
  // clock and beat phase
  input  wire logic               mclk_i,
  input  wire logic               echo_clock_i,
  // port pins
  output logic      [ADDR_W-1:0]  addr_o,
  output logic                    wsel_n_o,
  output logic                    rsel_n_o,
  output logic      [DATA_W-1:0]  d_o,
  output logic      [1:0]         nib_o,
  output logic      [3:0]         lane_o
);
  logic [DATA_W-1:0] shadow [int];
  logic [DATA_W-1:0] exp_q [$];

  initial
  begin
    addr_o = '0;
    wsel_n_o = 1'b1;
    rsel_n_o = 1'b1;
    d_o = '0;
    nib_o = 2'h0;
    lane_o = 4'h0;
  end

  // noise on idle pins so ignored inputs cannot look right by accident
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      wsel_n_o <= 1'b1;
      rsel_n_o <= 1'b1;
      addr_o <= ADDR_W'($urandom);
      d_o <= DATA_W'({$urandom, $urandom});
      nib_o <= 2'($urandom);
      lane_o <= 4'($urandom);
    end
  endtask

  // one four-beat burst; w picks write, full disables masking
  task automatic op(input bit w, input bit full, input logic [ADDR_W-1:0] a);
    logic [3:0]        m;
    logic [DATA_W-1:0] v;
    quiet(2'($urandom));
    @(negedge mclk_i);
    while (echo_clock_i !== 1'b0)
      @(negedge mclk_i);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk_i);
      m = full ? 4'h0 : 4'($urandom);
      v = DATA_W'({$urandom, $urandom});
      wsel_n_o <= (k == 0) ? !w : ((k == 2 && !w) | 1'($urandom));
      rsel_n_o <= (k == 0) ? w : ((k == 2 && w) | 1'($urandom));
      addr_o <= (k == 0) ? a : ADDR_W'($urandom);
      d_o <= v;
      lane_o <= m;
      nib_o <= 2'($urandom);
      for (int l = 0; l < 4; l++)
        if (w && !m[l])
          shadow[int'({a, 2'(k)})][l*9 +: 9] = v[l*9 +: 9];
      if (!w)
        exp_q.push_back(shadow[int'({a, 2'(k)})]);
    end
  endtask
endmodule // sbp_host_model

//--- verification/sbp_port_tb.sv
// Purpose: self-checking bench for sbp_port
// Assumes: host model fills a queue of expected read words
// Notes:   words are compared whenever the output enable is high
`timescale 1ns/1ns

module sbp_port_tb;
  localparam int DW = 36;
  localparam int AW = 17;

  logic          mclk;
  logic          rst;
  logic [AW-1:0] addr;
  logic          wsel_n;
  logic          rsel_n;
  logic [DW-1:0] d;
  logic [1:0]    nib_n;
  logic [3:0]    lane_n;
  logic [DW-1:0] q;
  logic          q_oe;
  logic          echo;
  logic          echo_n;
  logic [AW-1:0] addrs [6];
  int            mismatches;
  int            check_count;
  int            cyc;

  sbp_port #(.DATA_W(DW), .ADDR_W(AW)) u_sbp_port (.mclk_i(mclk),
    .rst_i(rst), .addr_i(addr), .write_port_select_n_i(wsel_n),
    .read_port_select_n_i(rsel_n), .d_i(d), .nibble_write_mask_n_i(nib_n),
    .lane_write_mask_n_i(lane_n), .q_o(q), .q_oe_o(q_oe),
    .echo_clock_o(echo), .echo_clock_n_o(echo_n));

  sbp_host_model #(.DATA_W(DW), .ADDR_W(AW)) u_sbp_host_model (
    .mclk_i(mclk), .echo_clock_i(echo), .addr_o(addr), .wsel_n_o(wsel_n),
    .rsel_n_o(rsel_n), .d_o(d), .nib_o(nib_n), .lane_o(lane_n));

  always #50 mclk = ~mclk;

  task automatic check_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // scoreboard: oldest note against each word shown
  always @(negedge mclk)
    if (!rst && q_oe !== 1'b0)
    begin
      check_bit(q_oe, 1'b1);
      if (u_sbp_host_model.exp_q.size() == 0)
        check_bit(q_oe, 1'b0);
      else
        check_word(q, u_sbp_host_model.exp_q.pop_front());
    end

  // ceiling well above the few hundred cycles the run needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(32'hE8A9));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check_bit(echo, 1'b1);
    check_bit(q_oe, 1'b0);
    // address bounds plus random middles
    for (int i = 0; i < 6; i++)
    begin
      addrs[i] = (i == 0) ? '0 : (i == 1) ? '1 : AW'($urandom);
      u_sbp_host_model.op(1'b1, 1'b1, addrs[i]);
    end
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 6; i++)
      begin
        u_sbp_host_model.op(1'b1, 1'b0, addrs[i]);
        u_sbp_host_model.op(1'b0, 1'b0, addrs[i]);
      end
    for (int i = 0; i < 6; i++)
      u_sbp_host_model.op(1'b0, 1'b0, addrs[i]);
    u_sbp_host_model.quiet(12);
    check_bit(u_sbp_host_model.exp_q.size() == 0, 1'b1);
    print_verdict();
  end
endmodule // sbp_port_tb
